// [pmw_defs.svh]
// Behaviour
// - software moves the chip from normal into idle or full power-down
// - idle keeps the oscillator running but gates the core clock only
// - peripherals keep their clock and work normally during idle
// - port and converter outputs hold their entry state while idle
// - any enabled interrupt or a hardware reset ends idle
// - power-down stops the oscillator and shuts down all peripherals
// - power-down holds port levels and floats the converter output
// - reset pin in power-down returns to normal, defaults, vector on release
// - power cycle gives defaults and start at the vector about 128 ms later
// - interval timer interrupt ends power-down and is then serviced
// - return from that service resumes after the power-down instruction
// - serial interrupt wakes from power-down only with serial wake enable set
// - external interrupt 0 wakes only with its power-down wake enable set
// - power-on reset holds below 2.45 V, then times out about 128 ms
// - power-on timeout counts oscillator cycles, longer with slower crystal
// - on supply decay reset is held until the supply is below 1 V
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH
// register byte offsets
`define PMW_OFF_CTRL 8'h00
`define PMW_OFF_STAT 8'h04
`define PMW_OFF_IRQ_STAT 8'h08
`define PMW_OFF_IRQ_MASK 8'h0C
// control field positions
`define PMW_BIT_IDLE 0
`define PMW_BIT_PDOWN 1
`define PMW_BIT_SER_WAKE 2
`define PMW_BIT_EXT_WAKE 3
// interrupt status bits
`define PMW_EV_IDLE_WAKE 0
`define PMW_EV_PD_WAKE 1
`define PMW_EV_POR_DONE 2
// timing
`define PMW_POR_TIME_MS 128
`define PMW_CLK_MHZ 100
`define PMW_POR_CYCLES (`PMW_POR_TIME_MS * 1000 * `PMW_CLK_MHZ)
`define PMW_ONE 1'b1
`define PMW_RESP_OK 2'h0
`define PMW_RESP_ERR 2'h2
`endif

// [pmw_pkg.sv]
package pmw_pkg;
  typedef enum logic [1:0] {
    PMW_NORMAL = 2'h0,
    PMW_IDLE = 2'h1,
    PMW_PDOWN = 2'h2,
    PMW_PORHOLD = 2'h3
  } pmw_mode_e;
  // wake sources from peripherals
  typedef struct packed {
    logic timer;
    logic serial;
    logic ext0;
    logic other;
  } pmw_wake_s;
endpackage

// [pmw_top.sv]
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.svh"
module pmw_top #(
  parameter int unsigned POR_CYCLES = `PMW_POR_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // reset pin and supply comparators (asynchronous)
  input wire logic reset_pin_i,
  input wire logic supply_above_por_i,
  input wire logic supply_above_min_i,
  // wake sources, levels from peripheral interrupt logic
  input wire pmw_pkg::pmw_wake_s wake_i,
  // core handshake
  input wire logic write_done_i,
  input wire logic reti_i,
  // pins and converter held state
  input wire logic [7:0] port_i,
  input wire logic [11:0] dac_i,
  output logic [7:0] port_o,
  output logic [11:0] dac_o,
  output logic dac_oe_o,
  // clock gating and reset outputs
  output logic core_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_run_o,
  output logic sys_reset_o,
  output logic wake_service_o,
  output logic resume_after_pd_o,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq_o
);
  localparam int CW = $clog2(POR_CYCLES + 1);

  // three-stage synchronisers for pins
  logic [2:0] rstp_sync_reg;
  logic [2:0] por_sync_reg;
  logic [2:0] min_sync_reg;
  logic [2:0] tmr_sync_reg;
  logic [2:0] ser_sync_reg;
  logic [2:0] ext_sync_reg;
  logic [2:0] oth_sync_reg;
  logic rstp_reg;
  logic por_ok_reg;
  logic min_ok_reg;
  logic tmr_w;
  logic ser_w;
  logic ext_w;
  logic oth_w;

  pmw_pkg::pmw_mode_e mode_reg;
  logic [CW-1:0] por_cnt_reg;
  logic ser_wake_en_reg;
  logic ext_wake_en_reg;
  logic pend_idle_reg;
  logic pend_pd_reg;
  logic woke_pd_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] ev_set;
  logic [7:0] port_hold_reg;
  logic [11:0] dac_hold_reg;
  logic pd_wake;
  logic any_irq;
  logic por_done;

  // agreement filter: second and third stage must match
  function automatic logic agree(input logic [2:0] s, input logic prev);
    agree = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  // true only for the four mapped word offsets, shared by write and read decode
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `PMW_OFF_CTRL) || (a == `PMW_OFF_STAT) ||
              (a == `PMW_OFF_IRQ_STAT) || (a == `PMW_OFF_IRQ_MASK);
  endfunction

  always_ff @(posedge clock_i) begin
    rstp_sync_reg <= {rstp_sync_reg[1:0], reset_pin_i};
    por_sync_reg <= {por_sync_reg[1:0], supply_above_por_i};
    min_sync_reg <= {min_sync_reg[1:0], supply_above_min_i};
    tmr_sync_reg <= {tmr_sync_reg[1:0], wake_i.timer};
    ser_sync_reg <= {ser_sync_reg[1:0], wake_i.serial};
    ext_sync_reg <= {ext_sync_reg[1:0], wake_i.ext0};
    oth_sync_reg <= {oth_sync_reg[1:0], wake_i.other};
  end

  // filtered pin levels
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rstp_reg <= 1'b0;
      por_ok_reg <= 1'b0;
      min_ok_reg <= 1'b0;
    end else begin
      rstp_reg <= agree(rstp_sync_reg, rstp_reg);
      por_ok_reg <= agree(por_sync_reg, por_ok_reg);
      min_ok_reg <= agree(min_sync_reg, min_ok_reg);
    end
  end

  assign tmr_w = tmr_sync_reg[2] & tmr_sync_reg[1];
  assign ser_w = ser_sync_reg[2] & ser_sync_reg[1];
  assign ext_w = ext_sync_reg[2] & ext_sync_reg[1];
  assign oth_w = oth_sync_reg[2] & oth_sync_reg[1];

  // only enabled sources end power-down; others are ignored
  assign pd_wake = tmr_w | (ser_w & ser_wake_en_reg) | (ext_w & ext_wake_en_reg);
  assign any_irq = tmr_w | ser_w | ext_w | oth_w;
  assign por_done = (por_cnt_reg == CW'(POR_CYCLES));

  // power-on timeout in oscillator cycles; hold while supply low, decay until below min
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      por_cnt_reg <= '0;
    end else if (!por_ok_reg || !min_ok_reg) begin
      por_cnt_reg <= '0;
    end else if (mode_reg == pmw_pkg::PMW_PORHOLD && !por_done) begin
      por_cnt_reg <= por_cnt_reg + CW'(1);
    end
  end

  // mode sequencer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_reg <= pmw_pkg::PMW_PORHOLD;
    end else if (!por_ok_reg || !min_ok_reg ||
                 (mode_reg == pmw_pkg::PMW_PORHOLD && !por_done)) begin
      mode_reg <= pmw_pkg::PMW_PORHOLD;
    end else if (rstp_reg) begin
      mode_reg <= pmw_pkg::PMW_NORMAL;
    end else begin
      case (mode_reg)
        pmw_pkg::PMW_PORHOLD: mode_reg <= pmw_pkg::PMW_NORMAL;
        pmw_pkg::PMW_NORMAL: begin
          if (write_done_i && pend_pd_reg) begin
            mode_reg <= pmw_pkg::PMW_PDOWN;
          end else if (write_done_i && pend_idle_reg) begin
            mode_reg <= pmw_pkg::PMW_IDLE;
          end
        end
        pmw_pkg::PMW_IDLE: begin
          if (any_irq) begin
            mode_reg <= pmw_pkg::PMW_NORMAL;
          end
        end
        pmw_pkg::PMW_PDOWN: begin
          if (pd_wake) begin
            mode_reg <= pmw_pkg::PMW_NORMAL;
          end
        end
        default: mode_reg <= pmw_pkg::PMW_PORHOLD;
      endcase
    end
  end

  // remember a power-down wake until the service routine returns
  always_ff @(posedge clock_i) begin
    if (rst_i || mode_reg == pmw_pkg::PMW_PORHOLD || rstp_reg) begin
      woke_pd_reg <= 1'b0;
    end else if (mode_reg == pmw_pkg::PMW_PDOWN && pd_wake) begin
      woke_pd_reg <= 1'b1;
    end else if (reti_i) begin
      woke_pd_reg <= 1'b0;
    end
  end

  // held pin state captured on leaving normal mode
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      port_hold_reg <= 8'h00;
      dac_hold_reg <= 12'h000;
    end else if (mode_reg == pmw_pkg::PMW_NORMAL) begin
      port_hold_reg <= port_i;
      dac_hold_reg <= dac_i;
    end
  end

  // output stage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      port_o <= 8'h00;
      dac_o <= 12'h000;
      dac_oe_o <= 1'b0;
    end else begin
      port_o <= (mode_reg == pmw_pkg::PMW_NORMAL) ? port_i : port_hold_reg;
      dac_o <= (mode_reg == pmw_pkg::PMW_NORMAL) ? dac_i : dac_hold_reg;
      dac_oe_o <= (mode_reg != pmw_pkg::PMW_PDOWN) && (mode_reg != pmw_pkg::PMW_PORHOLD);
    end
  end

  // clock enables and reset; wake path is combinational so it acts with osc stopped
  assign core_clk_en_o = (mode_reg == pmw_pkg::PMW_NORMAL);
  assign periph_clk_en_o = (mode_reg == pmw_pkg::PMW_NORMAL) || (mode_reg == pmw_pkg::PMW_IDLE);
  assign osc_run_o = (mode_reg != pmw_pkg::PMW_PDOWN) || pd_wake || rstp_reg;
  assign sys_reset_o = (mode_reg == pmw_pkg::PMW_PORHOLD) || rstp_reg;
  assign wake_service_o = woke_pd_reg;
  assign resume_after_pd_o = woke_pd_reg & reti_i;

  // axi4-lite slave
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;
  logic [31:0] rd_val;
  logic rd_ok;

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // hold address and data until both are present
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMW_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok(aw_addr_reg) ? `PMW_RESP_OK : `PMW_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register; mode requests wait for the core write to complete
  always_ff @(posedge clock_i) begin
    if (rst_i || sys_reset_o) begin
      pend_idle_reg <= 1'b0;
      pend_pd_reg <= 1'b0;
      ser_wake_en_reg <= 1'b0;
      ext_wake_en_reg <= 1'b0;
    end else begin
      if (wr_go && aw_addr_reg == `PMW_OFF_CTRL && w_strb_reg[0]) begin
        pend_idle_reg <= w_data_reg[`PMW_BIT_IDLE];
        pend_pd_reg <= w_data_reg[`PMW_BIT_PDOWN];
        ser_wake_en_reg <= w_data_reg[`PMW_BIT_SER_WAKE];
        ext_wake_en_reg <= w_data_reg[`PMW_BIT_EXT_WAKE];
      end else if (mode_reg != pmw_pkg::PMW_NORMAL) begin
        pend_idle_reg <= 1'b0;
        pend_pd_reg <= 1'b0;
      end
    end
  end

  // interrupt status: set wins over write-one-to-clear
  assign ev_set[`PMW_EV_IDLE_WAKE] = (mode_reg == pmw_pkg::PMW_IDLE) && any_irq && !rstp_reg;
  assign ev_set[`PMW_EV_PD_WAKE] = (mode_reg == pmw_pkg::PMW_PDOWN) && pd_wake && !rstp_reg;
  assign ev_set[`PMW_EV_POR_DONE] = (mode_reg == pmw_pkg::PMW_PORHOLD) && por_done && min_ok_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      if (wr_go && aw_addr_reg == `PMW_OFF_IRQ_STAT && w_strb_reg[0]) begin
        irq_stat_reg <= (irq_stat_reg & ~w_data_reg[2:0]) | ev_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev_set;
      end
      if (wr_go && aw_addr_reg == `PMW_OFF_IRQ_MASK && w_strb_reg[0]) begin
        irq_mask_reg <= w_data_reg[2:0];
      end
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = addr_ok(s_axi_araddr);
    case (s_axi_araddr)
      `PMW_OFF_CTRL: rd_val = {28'h0000000, ext_wake_en_reg, ser_wake_en_reg,
                               pend_pd_reg, pend_idle_reg};
      `PMW_OFF_STAT: rd_val = {26'h0000000, woke_pd_reg, por_ok_reg, min_ok_reg,
                               rstp_reg, mode_reg};
      `PMW_OFF_IRQ_STAT: rd_val = {29'h00000000, irq_stat_reg};
      `PMW_OFF_IRQ_MASK: rd_val = {29'h00000000, irq_mask_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  // read response
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PMW_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `PMW_RESP_OK : `PMW_RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [pmw_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pmw_core_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // observed bus and service state
  input wire logic b_done_i,
  input wire logic service_i,
  // core strobes
  output logic write_done_o,
  output logic reti_o
);
  logic [2:0] wd_reg;
  logic [2:0] rt_reg;
  // instruction completes three cycles after its write response
  always_ff @(posedge clock_i) begin
    if (rst_i) wd_reg <= 3'h0;
    else wd_reg <= {wd_reg[1:0], b_done_i};
  end
  assign write_done_o = wd_reg[2];
  // service routine returns five cycles after a wake
  always_ff @(posedge clock_i) begin
    if (rst_i || !service_i || reti_o) rt_reg <= 3'h0;
    else rt_reg <= rt_reg + 3'h1;
  end
  assign reti_o = (rt_reg == 3'h5);
endmodule
`default_nettype wire

// [pmw_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.svh"
module pmw_checker #(
  parameter int unsigned POR_CYCLES = `PMW_POR_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // watched inputs
  input wire logic reset_pin_i,
  input wire logic supply_above_por_i,
  input wire pmw_pkg::pmw_wake_s wake_i,
  input wire logic reti_i,
  // watched outputs
  input wire logic [7:0] port_o,
  input wire logic [11:0] dac_o,
  input wire logic dac_oe_o,
  input wire logic core_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic osc_run_o,
  input wire logic sys_reset_o,
  input wire logic wake_service_o,
  input wire logic resume_after_pd_o
);
  int unsigned cnt_reg;
  int unsigned quiet_reg;
  logic [7:0] sup_reg;
  logic idle_w;
  logic pd_w;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  assign idle_w = !core_clk_en_o && periph_clk_en_o;
  assign pd_w = !periph_clk_en_o && !sys_reset_o;
  // cycles since the supply came up, restarted after a settled drop
  always_ff @(posedge clock_i) begin
    sup_reg <= {sup_reg[6:0], supply_above_por_i};
    if (rst_i || sup_reg == 8'h00) cnt_reg <= 0;
    else if (cnt_reg < POR_CYCLES + 16) cnt_reg <= cnt_reg + 1;
  end
  // cycles with no wake source and no reset pin
  always_ff @(posedge clock_i) begin
    if (reset_pin_i || wake_i != 4'h0) quiet_reg <= 0;
    else if (quiet_reg < 15) quiet_reg <= quiet_reg + 1;
  end
  property p_por_hold;
    cnt_reg < POR_CYCLES |-> sys_reset_o;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset released early");
  property p_por_end;
    cnt_reg == POR_CYCLES + 8 && quiet_reg > 8 |-> !sys_reset_o && core_clk_en_o;
  endproperty
  a_por_end: assert property (p_por_end) else $error("reset not released");
  property p_gate;
    core_clk_en_o |-> periph_clk_en_o && osc_run_o;
  endproperty
  a_gate: assert property (p_gate) else $error("core clock without peripherals");
  property p_idle_hold;
    idle_w && $past(idle_w) |-> $stable(port_o) && $stable(dac_o) && dac_oe_o;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("pins moved in idle");
  property p_pd_hold;
    pd_w && $past(pd_w) |-> $stable(port_o) && !dac_oe_o && !core_clk_en_o;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("pins wrong in power-down");
  property p_osc_stop;
    pd_w && quiet_reg > 5 |-> !osc_run_o;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator runs");
  property p_timer_wake;
    pd_w && wake_i.timer |-> ##[1:6] core_clk_en_o;
  endproperty
  a_timer_wake: assert property (p_timer_wake) else $error("timer did not wake");
  property p_idle_wake;
    idle_w && wake_i != 4'h0 |-> ##[1:6] core_clk_en_o;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not left");
  property p_svc_set;
    $rose(wake_service_o) |-> $past(pd_w);
  endproperty
  a_svc_set: assert property (p_svc_set) else $error("service without wake");
  property p_resume;
    wake_service_o && reti_i |-> resume_after_pd_o ##1 !wake_service_o;
  endproperty
  a_resume: assert property (p_resume) else $error("resume missing");
  property p_pin;
    reset_pin_i [*6] |-> sys_reset_o;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin ignored");
  c_pd_wake: cover property (pd_w ##1 core_clk_en_o);
  c_resume: cover property (resume_after_pd_o);
  c_pin_pd: cover property (pd_w && reset_pin_i);
endmodule
`default_nettype wire

// [tb_power_mode_wake_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_power_mode_wake_control;
  typedef struct packed {
    logic [3:0] ctrl;
    pmw_pkg::pmw_wake_s wk;
    logic [2:0] enter;
    logic [2:0] leave;
    logic svc;
  } pmw_row_s;
  localparam int unsigned POR = 20;
  // control write, wake source, clocks on entry, clocks after wake, service
  localparam pmw_row_s ROWS [8] = '{
    '{4'h2, 4'h4, 3'h0, 3'h0, 1'b0}, '{4'h2, 4'h2, 3'h0, 3'h0, 1'b0},
    '{4'h3, 4'h1, 3'h0, 3'h0, 1'b0}, '{4'h6, 4'h4, 3'h0, 3'h7, 1'b1},
    '{4'hA, 4'h2, 3'h0, 3'h7, 1'b1}, '{4'h2, 4'h8, 3'h0, 3'h7, 1'b1},
    '{4'h1, 4'h1, 3'h3, 3'h7, 1'b0}, '{4'h1, 4'h8, 3'h3, 3'h7, 1'b0}};
  logic clock_i, rst_i, reset_pin_i, supply_above_por_i, supply_above_min_i;
  logic write_done_i, reti_i, dac_oe_o, core_clk_en_o, periph_clk_en_o, osc_run_o;
  logic sys_reset_o, wake_service_o, resume_after_pd_o, irq_o;
  pmw_pkg::pmw_wake_s wake_i;
  logic [7:0] port_i, port_o, s_axi_awaddr, s_axi_araddr;
  logic [11:0] dac_i, dac_o;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_mismatch;
  int checks;
  pmw_top #(.POR_CYCLES(POR)) uut (
    .clock_i(clock_i), .rst_i(rst_i), .reset_pin_i(reset_pin_i),
    .supply_above_por_i(supply_above_por_i), .supply_above_min_i(supply_above_min_i),
    .wake_i(wake_i), .write_done_i(write_done_i), .reti_i(reti_i), .port_i(port_i),
    .dac_i(dac_i), .port_o(port_o), .dac_o(dac_o), .dac_oe_o(dac_oe_o),
    .core_clk_en_o(core_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .osc_run_o(osc_run_o), .sys_reset_o(sys_reset_o), .wake_service_o(wake_service_o),
    .resume_after_pd_o(resume_after_pd_o), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_o(irq_o));
  pmw_core_model u_core (
    .clock_i(clock_i), .rst_i(rst_i), .b_done_i(s_axi_bvalid && s_axi_bready),
    .service_i(wake_service_o), .write_done_o(write_done_i), .reti_o(reti_i));
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one bus transfer, write or read
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e, output logic [31:0] r);
    logic aw, w, ok;
    int n;
    aw = wr;
    w = wr;
    ok = 1'b0;
    r = 32'h0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clock_i);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (!wr && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid) begin
        ok = 1'b1;
        r = s_axi_rdata;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        chk(32'(wr ? s_axi_bresp : s_axi_rresp), 32'(e));
      end
    end
    if (!ok) chk(32'h0, 32'h1);
    // let an edge pass so the next call never drives the same strobe in this step
    @(posedge clock_i);
  endtask
  // wait for reset release and check that it took at least lo cycles
  task automatic wait_rel(input int lo);
    int n;
    for (n = 0; n < 200 && sys_reset_o !== 1'b0; n++) @(posedge clock_i);
    chk(32'(sys_reset_o), 32'h0);
    chk(32'(n >= lo), 32'h1);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    repeat (5000) @(posedge clock_i);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {rst_i, supply_above_por_i, supply_above_min_i} = 3'h7;
    {reset_pin_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wake_i, port_i, dac_i} = '0;
    repeat (16) @(posedge clock_i);
    chk(32'(sys_reset_o), 32'h1);
    rst_i <= 1'b0;
    wait_rel(POR);
    axi(1'b0, 8'h04, 32'h0, 2'h0, q);
    chk(q, 32'h18);
    // mode entry, pin hold and wake for each row
    foreach (ROWS[i]) begin
      port_i <= 8'h5A ^ 8'(i);
      dac_i <= 12'hA5C;
      axi(1'b1, 8'h00, {28'h0, ROWS[i].ctrl}, 2'h0, q);
      chk(32'(core_clk_en_o), 32'h1);
      repeat (8) @(posedge clock_i);
      port_i <= 8'hFF;
      dac_i <= 12'h000;
      repeat (3) @(posedge clock_i);
      chk(32'({core_clk_en_o, periph_clk_en_o, dac_oe_o}), 32'(ROWS[i].enter));
      chk(32'({dac_o, port_o}), {12'h0, 12'hA5C, 8'h5A ^ 8'(i)});
      wake_i <= ROWS[i].wk;
      repeat (8) @(posedge clock_i);
      chk(32'({core_clk_en_o, periph_clk_en_o, dac_oe_o}), 32'(ROWS[i].leave));
      chk(32'(wake_service_o), 32'(ROWS[i].svc));
      wake_i <= '0;
      if (ROWS[i].leave == 3'h0) begin
        reset_pin_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        chk(32'(sys_reset_o), 32'h1);
        reset_pin_i <= 1'b0;
        wait_rel(0);
        repeat (2) @(posedge clock_i);
        chk(32'({core_clk_en_o, periph_clk_en_o, dac_oe_o}), 32'h7);
      end
      repeat (12) @(posedge clock_i);
      chk(32'(wake_service_o), 32'h0);
    end
    // unmapped place answers with an error both ways
    axi(1'b1, 8'h10, 32'h0, 2'h2, q);
    axi(1'b0, 8'h10, 32'h0, 2'h2, q);
    // interrupt status from the wakes above, unmasked, cleared, masked again
    axi(1'b0, 8'h08, 32'h0, 2'h0, q);
    chk(q, 32'h7);
    axi(1'b1, 8'h0C, 32'h7, 2'h0, q);
    chk(32'(irq_o), 32'h1);
    axi(1'b1, 8'h08, 32'h7, 2'h0, q);
    axi(1'b0, 8'h08, 32'h0, 2'h0, q);
    chk(q, 32'h0);
    chk(32'(irq_o), 32'h0);
    axi(1'b1, 8'h0C, 32'h0, 2'h0, q);
    axi(1'b0, 8'h0C, 32'h0, 2'h0, q);
    chk(q, 32'h0);
    // supply decay and power cycle
    supply_above_por_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    chk(32'(sys_reset_o), 32'h1);
    supply_above_por_i <= 1'b1;
    wait_rel(POR);
    repeat (2) @(posedge clock_i);
    chk(32'({core_clk_en_o, periph_clk_en_o, dac_oe_o}), 32'h7);
    report_and_stop();
  end
endmodule
bind pmw_top pmw_checker #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .reset_pin_i(reset_pin_i),
  .supply_above_por_i(supply_above_por_i), .wake_i(wake_i), .reti_i(reti_i),
  .port_o(port_o), .dac_o(dac_o), .dac_oe_o(dac_oe_o), .core_clk_en_o(core_clk_en_o),
  .periph_clk_en_o(periph_clk_en_o), .osc_run_o(osc_run_o), .sys_reset_o(sys_reset_o),
  .wake_service_o(wake_service_o), .resume_after_pd_o(resume_after_pd_o));
`default_nettype wire
